// [verif/swps_host_model.sv]
// host controller model driving bus events and watchdog restarts
`timescale 1ns/1ps
`default_nettype none
module swps_host_model (
  input wire logic i_sys_clk,
  output swps_pkg::swps_bus_ev_t o_bus_ev,
  output logic o_restart
);
  import swps_pkg::*;
  initial begin
    o_bus_ev = '0;
    o_restart = 1'h0;
  end
  // one-cycle event, qualifiers inverted once no longer valid
  task automatic ev(input logic [5:0] v);
    @(negedge i_sys_clk) o_bus_ev = swps_bus_ev_t'(v);
    @(negedge i_sys_clk) o_bus_ev = swps_bus_ev_t'({4'h0, ~v[1:0]});
  endtask
  // restart pulse, never shorter than the minimum width
  task automatic restart(input int n);
    @(negedge i_sys_clk) o_restart = 1'h1;
    repeat ((n < RESTART_PULSE_CYC) ? RESTART_PULSE_CYC : n) @(negedge i_sys_clk);
    o_restart = 1'h0;
  endtask
endmodule
`default_nettype wire

// [verif/swps_props.sv]
// assertions for the supervisor power-state and watchdog block
`timescale 1ns/1ps
`default_nettype none
module swps_props #(
  parameter int NV_CYC = 50,
  parameter int HOLD_CYC = 100,
  parameter int SEL10_CYC = 200,
  parameter int SEL01_CYC = 300,
  parameter int SEL00_CYC = 400
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire swps_pkg::swps_bus_ev_t i_bus_ev,
  input wire logic i_wdog_period_sel_hi,
  input wire logic i_wdog_period_sel_lo,
  input wire logic i_wdog_restart,
  input wire logic o_active,
  input wire logic o_write_busy,
  input wire logic o_addr_ack,
  input wire logic o_reset_out,
  input wire swps_pkg::swps_pwr_t o_pwr_state
);
  import swps_pkg::*;
  int busy_n;
  int hold_n;
  int idle_n;
  int lim;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  // counters for write length, reset hold and watchdog idle time
  always_ff @(posedge i_sys_clk) begin
    busy_n <= o_write_busy ? busy_n + 1 : 0;
    hold_n <= (!i_resetn || !o_reset_out) ? 0 : hold_n + 1;
    idle_n <= (o_reset_out || i_wdog_restart) ? 0 : idle_n + 1;
  end
  // expected watchdog limit from the period select
  assign lim = i_wdog_period_sel_hi ? SEL10_CYC : i_wdog_period_sel_lo ? SEL01_CYC : SEL00_CYC;
  AST_START_ACTIVE: assert property (i_bus_ev.start && !o_write_busy |=> o_active)
    else $error("start did not wake the device");
  AST_STOP_IDLE: assert property (i_bus_ev.stop && !i_bus_ev.write_armed && !o_write_busy
    |-> ##[1:22] !o_active) else $error("no standby after plain stop");
  AST_WRITE_GO: assert property (i_bus_ev.stop && i_bus_ev.write_armed && !o_write_busy
    |=> o_write_busy && o_active) else $error("write did not start at stop");
  AST_WRITE_AWAKE: assert property (o_write_busy |-> o_active)
    else $error("standby during write");
  AST_WRITE_LEN: assert property ($fell(o_write_busy) |-> busy_n == NV_CYC && !o_active)
    else $error("write length or standby wrong");
  AST_ACK_GIVEN: assert property (i_bus_ev.addr_done && i_bus_ev.addr_match && !o_write_busy
    |=> o_addr_ack) else $error("matching address not acknowledged");
  AST_ACK_BUSY: assert property (i_bus_ev.addr_done && o_write_busy |=> !o_addr_ack)
    else $error("acknowledge during write");
  AST_RESET_HOLD: assert property ($fell(o_reset_out) |-> hold_n >= HOLD_CYC - 1
    && hold_n <= HOLD_CYC + 2) else $error("reset hold length wrong");
  AST_WDOG_LIMIT: assert property ($rose(o_reset_out) && $past(i_resetn)
    |-> idle_n >= lim - 2 && idle_n <= lim + 3) else $error("watchdog period wrong");
  cover property ($fell(o_write_busy));
  cover property (o_addr_ack);
  cover property ($rose(o_reset_out));
endmodule
bind swps_top swps_props #(.NV_CYC(NV_CYC), .HOLD_CYC(HOLD_CYC), .SEL10_CYC(SEL10_CYC),
  .SEL01_CYC(SEL01_CYC), .SEL00_CYC(SEL00_CYC)) u_props (.i_sys_clk(i_sys_clk),
  .i_resetn(i_resetn), .i_bus_ev(i_bus_ev), .i_wdog_period_sel_hi(i_wdog_period_sel_hi),
  .i_wdog_period_sel_lo(i_wdog_period_sel_lo), .i_wdog_restart(i_wdog_restart),
  .o_active(o_active), .o_write_busy(o_write_busy), .o_addr_ack(o_addr_ack),
  .o_reset_out(o_reset_out), .o_pwr_state(o_pwr_state));
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench for the supervisor power-state and watchdog block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import swps_pkg::*;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic sel_hi = 1'h1;
  logic sel_lo = 1'h1;
  swps_bus_ev_t bus_ev;
  logic restart, active, busy, ack, rst_out;
  swps_pwr_t pwr;
  int errors = 0;
  int tests_run = 0;
  int n;
  always #5 clk = ~clk;
  swps_host_model u_host (.i_sys_clk(clk), .o_bus_ev(bus_ev), .o_restart(restart));
  swps_top #(.NV_CYC(50), .SEL10_CYC(200), .SEL01_CYC(300), .SEL00_CYC(400), .HOLD_CYC(100))
    u_dut (.i_sys_clk(clk), .i_resetn(resetn), .i_bus_ev(bus_ev), .i_wdog_restart(restart),
    .i_wdog_period_sel_hi(sel_hi), .i_wdog_period_sel_lo(sel_lo), .o_active(active),
    .o_write_busy(busy), .o_addr_ack(ack), .o_reset_out(rst_out), .o_pwr_state(pwr));
  task automatic report_and_stop();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // compare one level
  task automatic chk(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // compare the power state
  task automatic chk_st(input swps_pwr_t got, input swps_pwr_t exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // compare a cycle count against a window
  task automatic rng(input int c, input int lo, input int hi);
    tests_run++;
    if (c < lo || c > hi) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h..%h", $time, c, lo, hi);
    end
  endtask
  // bounded wait for a level, returns cycles spent
  task automatic wait_lvl(ref logic s, input logic v, output int c);
    c = 0;
    while (s !== v) begin
      @(negedge clk);
      c++;
      if (c > 2000) begin
        errors++;
        report_and_stop();
      end
    end
  endtask
  // address byte: eight bit clocks then the byte end
  task automatic addr(input logic [5:0] v);
    u_host.ev(6'h20);
    repeat (8) u_host.ev(6'h08);
    u_host.ev(v);
  endtask
  // wake on start, plain stop back to standby
  task automatic t_read();
    u_host.ev(6'h20);
    chk(active, 1'h1);
    u_host.ev(6'h10);
    chk_st(pwr, SWPS_STOPPING);
    wait_lvl(active, 1'h0, n);
    rng(n, 0, 21);
  endtask
  // wrong address drops out on the ninth bus clock
  task automatic t_miss();
    addr(6'h04);
    chk(ack, 1'h0);
    chk(active, 1'h1);
    u_host.ev(6'h08);
    wait_lvl(active, 1'h0, n);
    rng(n, 0, 2);
  endtask
  // write, polling refused while busy, then accepted
  task automatic t_write();
    addr(6'h06);
    chk(ack, 1'h1);
    u_host.ev(6'h11);
    chk(busy, 1'h1);
    chk_st(pwr, SWPS_WRITING);
    u_host.ev(6'h20);
    u_host.ev(6'h06);
    chk(ack, 1'h0);
    wait_lvl(busy, 1'h0, n);
    rng(n, 44, 47);
    chk(active, 1'h0);
    u_host.ev(6'h20);
    u_host.ev(6'h06);
    chk(ack, 1'h1);
    u_host.ev(6'h10);
    wait_lvl(active, 1'h0, n);
  endtask
  // reset in mid-write drops the write and restarts the power-up hold
  task automatic t_rst();
    addr(6'h06);
    u_host.ev(6'h11);
    chk(busy, 1'h1);
    resetn = 1'h0;
    repeat (2) @(negedge clk);
    chk(busy, 1'h0);
    chk(active, 1'h0);
    chk(rst_out, 1'h1);
    chk_st(pwr, SWPS_STANDBY);
    resetn = 1'h1;
    wait_lvl(rst_out, 1'h0, n);
    rng(n, 98, 103);
  endtask
  // watchdog expiry for one period code, then reset hold
  task automatic t_wdog(input logic [1:0] code, input int lim);
    {sel_hi, sel_lo} = code;
    u_host.restart(110);
    wait_lvl(rst_out, 1'h1, n);
    rng(n, lim - 2, lim + 3);
    wait_lvl(rst_out, 1'h0, n);
    rng(n, 98, 103);
  endtask
  initial begin
    repeat (8) @(negedge clk);
    resetn = 1'h1;
    chk(rst_out, 1'h1);
    wait_lvl(rst_out, 1'h0, n);
    rng(n, 98, 103);
    t_read();
    t_miss();
    t_write();
    t_wdog(2'h2, 200);
    t_wdog(2'h1, 300);
    t_wdog(2'h0, 400);
    {sel_hi, sel_lo} = 2'h3;
    repeat (600) @(negedge clk);
    chk(rst_out, 1'h0);
    t_rst();
    report_and_stop();
  end
endmodule
`default_nettype wire

// [verilog/swps_pkg.sv]
// package for the supervisor watchdog and power-state block
package swps_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  // standby return after a plain stop, longest time in ns
  localparam int STOP_STANDBY_NS = 200;
  localparam int STOP_STANDBY_CYC = (STOP_STANDBY_NS / CLK_PERIOD_NS < 1) ? 1 :
    STOP_STANDBY_NS / CLK_PERIOD_NS;
  // bus clock cycles after start before a mismatched address returns to standby
  localparam int SEL_MISS_SCL_CYCLES = 9;
  // nonvolatile write time in ms, typical and maximum
  localparam int NV_WRITE_TYP_MS = 5;
  localparam int NV_WRITE_MAX_MS = 10;
  localparam int NV_WRITE_CYC = NV_WRITE_TYP_MS * (CLK_HZ / 1000);
  // watchdog periods in us (typical values)
  localparam int WDOG_SEL10_US = 200_000;
  localparam int WDOG_SEL01_US = 600_000;
  localparam int WDOG_SEL00_US = 1_400_000;
  localparam int WDOG_SEL10_CYC = WDOG_SEL10_US * (CLK_HZ / 1_000_000);
  localparam int WDOG_SEL01_CYC = WDOG_SEL01_US * (CLK_HZ / 1_000_000);
  localparam int WDOG_SEL00_CYC = WDOG_SEL00_US * (CLK_HZ / 1_000_000);
  // reset hold after power-up or watchdog expiry, typical, in ms
  localparam int RESET_HOLD_MS = 200;
  localparam int RESET_HOLD_CYC = RESET_HOLD_MS * (CLK_HZ / 1000);
  // least restart pulse width in us
  localparam int RESTART_PULSE_US = 1;
  localparam int RESTART_PULSE_CYC = RESTART_PULSE_US * (CLK_HZ / 1_000_000);
  // watchdog period select codes
  localparam logic [1:0] WDOG_SEL_SHORT = 2'h2;
  localparam logic [1:0] WDOG_SEL_MID = 2'h1;
  localparam logic [1:0] WDOG_SEL_LONG = 2'h0;
  localparam logic [1:0] WDOG_SEL_OFF = 2'h3;
  // events decoded by the bus front end
  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic addr_done;
    logic addr_match;
    logic write_armed;
  } swps_bus_ev_t;
  typedef enum logic [1:0] {
    SWPS_STANDBY,
    SWPS_ACTIVE,
    SWPS_STOPPING,
    SWPS_WRITING
  } swps_pwr_t;
endpackage

// [verilog/swps_top.sv]
// power-state, write timing and watchdog supervisor top
`timescale 1ns/1ps
`default_nettype none
// Function
// - each start outside a write makes the device active, and a mismatched address returns it to standby nine bus clocks later.
// - a stop that does not launch a write returns the device to standby within 200 ns.
// - a stop that launches a write keeps the device active until the write has finished.
// - the nonvolatile write is self-timed from the stop, 5 ms typical and never over 10 ms.
// - while a write is running the address byte is not acknowledged, and afterwards it is.
// - the two-bit period select picks 200 ms, 600 ms or 1.4 s as watchdog timeout, or turns the watchdog off with code 3.
// - after power-up the reset output is held for the reset timeout before release.
module swps_top #(
  parameter int NV_CYC = swps_pkg::NV_WRITE_CYC,
  parameter int STOP_CYC = swps_pkg::STOP_STANDBY_CYC,
  parameter int SEL10_CYC = swps_pkg::WDOG_SEL10_CYC,
  parameter int SEL01_CYC = swps_pkg::WDOG_SEL01_CYC,
  parameter int SEL00_CYC = swps_pkg::WDOG_SEL00_CYC,
  parameter int HOLD_CYC = swps_pkg::RESET_HOLD_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire swps_pkg::swps_bus_ev_t i_bus_ev,
  input wire logic i_wdog_period_sel_hi,
  input wire logic i_wdog_period_sel_lo,
  input wire logic i_wdog_restart,
  output logic o_active,
  output logic o_write_busy,
  output logic o_addr_ack,
  output logic o_reset_out,
  output swps_pkg::swps_pwr_t o_pwr_state
);
  import swps_pkg::*;
  initial begin
    if (NV_CYC < 2 || STOP_CYC < 1) begin
      $error("swps_top: counts too small");
    end
    if (64'(NV_CYC) * 64'(CLK_PERIOD_NS) > 64'(NV_WRITE_MAX_MS) * 64'd1000000) begin
      $error("swps_top: write time above maximum");
    end
  end
  swps_pwr_t state, next_state;
  logic [31:0] cnt, next_cnt;
  logic [3:0] scl_cnt, next_scl_cnt;
  logic miss_pending, next_miss_pending;
  logic ack, next_ack;
  logic active, next_active;
  logic busy, next_busy;

  // power state sequencing
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_scl_cnt = scl_cnt;
    next_miss_pending = miss_pending;
    next_ack = 1'b0;
    case (state)
      SWPS_STANDBY: begin
        if (i_bus_ev.start) begin
          next_state = SWPS_ACTIVE;
          next_scl_cnt = 4'h0;
          next_miss_pending = 1'b0;
        end
      end
      SWPS_ACTIVE: begin
        if (i_bus_ev.start) begin
          next_scl_cnt = 4'h0;
          next_miss_pending = 1'b0;
        end else if (i_bus_ev.stop) begin
          if (i_bus_ev.write_armed) begin
            next_state = SWPS_WRITING;
          end else begin
            next_state = SWPS_STOPPING;
          end
          next_cnt = 32'h0;
        end else begin
          if (i_bus_ev.addr_done) begin
            next_ack = i_bus_ev.addr_match;
            next_miss_pending = !i_bus_ev.addr_match;
          end
          if (i_bus_ev.scl_rise && scl_cnt != 4'hf) begin
            next_scl_cnt = scl_cnt + 4'h1;
          end
          if ((miss_pending || (i_bus_ev.addr_done && !i_bus_ev.addr_match)) &&
              i_bus_ev.scl_rise && scl_cnt >= 4'(SEL_MISS_SCL_CYCLES - 1)) begin
            next_state = SWPS_STANDBY;
          end
        end
      end
      SWPS_STOPPING: begin
        if (i_bus_ev.start) begin
          next_state = SWPS_ACTIVE;
          next_scl_cnt = 4'h0;
          next_miss_pending = 1'b0;
        end else if (cnt >= 32'(STOP_CYC - 1)) begin
          next_state = SWPS_STANDBY;
        end else begin
          next_cnt = cnt + 32'h1;
        end
      end
      SWPS_WRITING: begin
        // inputs ignored, address never acknowledged while busy
        next_ack = 1'b0;
        if (cnt >= 32'(NV_CYC - 1)) begin
          next_state = SWPS_STANDBY;
        end else begin
          next_cnt = cnt + 32'h1;
        end
      end
      default: begin
        next_state = SWPS_STANDBY;
      end
    endcase
    next_active = next_state != SWPS_STANDBY;
    next_busy = next_state == SWPS_WRITING;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      state <= SWPS_STANDBY;
      cnt <= 32'h0;
      scl_cnt <= 4'h0;
      miss_pending <= 1'b0;
      ack <= 1'b0;
      active <= 1'b0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      scl_cnt <= next_scl_cnt;
      miss_pending <= next_miss_pending;
      ack <= next_ack;
      active <= next_active;
      busy <= next_busy;
    end
  end
  assign o_active = active;
  assign o_write_busy = busy;
  assign o_addr_ack = ack;
  assign o_pwr_state = state;

  // watchdog and reset generator
  swps_wdog #(
    .SEL10_CYC(SEL10_CYC),
    .SEL01_CYC(SEL01_CYC),
    .SEL00_CYC(SEL00_CYC),
    .HOLD_CYC(HOLD_CYC),
    .PULSE_CYC(RESTART_PULSE_CYC)
  ) u_wdog (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_period_sel({i_wdog_period_sel_hi, i_wdog_period_sel_lo}),
    .i_restart(i_wdog_restart),
    .o_reset_out(o_reset_out)
  );
endmodule
`default_nettype wire

// [verilog/swps_wdog.sv]
// watchdog timer with reset hold
`timescale 1ns/1ps
`default_nettype none
module swps_wdog #(
  parameter int SEL10_CYC = swps_pkg::WDOG_SEL10_CYC,
  parameter int SEL01_CYC = swps_pkg::WDOG_SEL01_CYC,
  parameter int SEL00_CYC = swps_pkg::WDOG_SEL00_CYC,
  parameter int HOLD_CYC = swps_pkg::RESET_HOLD_CYC,
  parameter int PULSE_CYC = swps_pkg::RESTART_PULSE_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [1:0] i_period_sel,
  input wire logic i_restart,
  output logic o_reset_out
);
  import swps_pkg::*;
  initial begin
    if (SEL10_CYC < 2 || SEL01_CYC < 2 || SEL00_CYC < 2 || HOLD_CYC < 2 || PULSE_CYC < 1) begin
      $error("swps_wdog: counts too small");
    end
  end
  logic [31:0] hold_cnt, next_hold_cnt;
  logic [31:0] wd_cnt, next_wd_cnt;
  logic [31:0] pulse_cnt, next_pulse_cnt;
  logic rst_out, next_rst_out;
  logic [31:0] limit;
  logic restart_ok;

  // period chosen by select, long restart pulses only count
  always_comb begin
    limit = 32'(SEL00_CYC);
    if (i_period_sel == WDOG_SEL_SHORT) begin
      limit = 32'(SEL10_CYC);
    end else if (i_period_sel == WDOG_SEL_MID) begin
      limit = 32'(SEL01_CYC);
    end
    restart_ok = !i_restart && pulse_cnt >= 32'(PULSE_CYC);
    next_pulse_cnt = i_restart ? ((pulse_cnt == 32'hffffffff) ? pulse_cnt : pulse_cnt + 32'h1)
      : 32'h0;
    next_rst_out = rst_out;
    next_hold_cnt = hold_cnt;
    next_wd_cnt = wd_cnt;
    if (rst_out) begin
      // hold reset, then release and restart watchdog
      if (hold_cnt >= 32'(HOLD_CYC - 1)) begin
        next_rst_out = 1'b0;
        next_wd_cnt = 32'h0;
      end else begin
        next_hold_cnt = hold_cnt + 32'h1;
      end
    end else if (i_period_sel == WDOG_SEL_OFF) begin
      next_wd_cnt = 32'h0;
    end else if (restart_ok) begin
      next_wd_cnt = 32'h0;
    end else if (wd_cnt >= limit - 32'h1) begin
      next_rst_out = 1'b1;
      next_hold_cnt = 32'h0;
    end else begin
      next_wd_cnt = wd_cnt + 32'h1;
    end
  end

  // state registers; reset starts the power-up hold
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      rst_out <= 1'b1;
      hold_cnt <= 32'h0;
      wd_cnt <= 32'h0;
      pulse_cnt <= 32'h0;
    end else begin
      rst_out <= next_rst_out;
      hold_cnt <= next_hold_cnt;
      wd_cnt <= next_wd_cnt;
      pulse_cnt <= next_pulse_cnt;
    end
  end
  assign o_reset_out = rst_out;
endmodule
`default_nettype wire
